// >>> hdl/sdm_sequencer.v
// What this block does
// R1: Edge bit clear counts rising step edges; set counts both edges.
// R2: Travel-sense level sampled on each active edge picks direction.
// R3: Resolution selectable: fullstep or 2 to 256 microsteps.
// R4: Sense low increments counter, high decrements, by resolution step size.
// R5: Counter drives sine and cosine lookup for both coil targets.
// R6: In direct mode serially supplied coil values go straight to coils.
// R7: Interface-select low gives standalone straps; high enables serial.
// R8: Power-stage disable high floats all motor outputs.
// R9: Controller drives chip select low for each serial transaction.
// R10: Serial data out driven only while selected, else released.
// R11: Strap toggle/tristate detection only in standalone mode.
// R12: Internal oscillator when clock pin low, else external clock.
// R13: Load-speed feature off while its enable input is low.
// R14: Load-speed gate input accepted; readiness reported on ready output.
// R15: Under near-stall load the velocity drops and status is fed back.
// R16: Each serial frame shifts 40 bits out and 40 bits in.
// R17: Step and sense inputs synchronised before edge detection.
// R18: Microstep counter wraps at the end of its range.
`timescale 1ns/1ps
`include "sdm_defs.vh"
module sdm_sequencer (
	input wire clk, // 40 MHz system clock
	input wire rst_n, // Synchronous reset, active low
	input wire psel, // APB select
	input wire penable, // APB access phase
	input wire pwrite, // APB write
	input wire [11:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error on unmapped address
	input wire step_in, // Step pulses
	input wire travel_sense, // Direction level
	input wire interface_select, // High selects serial interface
	input wire power_stage_disable_n, // High switches power stage off
	input wire serial_select_n_or_strap3, // Chip select or strap
	input wire serial_clock_or_strap2, // Serial clock or strap
	input wire serial_in_or_strap1, // Serial data in or strap
	input wire serial_out_or_strap0_in, // Strap level on shared pin
	output reg serial_out_or_strap0_out, // Serial data out
	output reg serial_out_or_strap0_oe, // Output enable of data out
	input wire load_speed_enable_in, // Load-speed enable or strap
	input wire load_speed_gate_in, // Axis gating or strap
	input wire stall_near, // Load near stall from load sensing
	output reg load_speed_ready_out, // Load-speed ready
	output reg step_hold, // Step slowdown request
	input wire ext_clock_present, // External clock detected on clock pin
	output reg clock_source_ext, // Clock source select
	output reg power_stage_on, // Power stage enable
	output reg strap_detect_en, // Strap toggle detection enable
	output reg signed [8:0] coil_a, // Coil A current target
	output reg signed [8:0] coil_b // Coil B current target
);
	reg [31:0] ctrl;
	reg [31:0] direct;
	reg [`SDM_CNT_W-1:0] count;
	reg [1:0] step_sync;
	reg [1:0] sense_sync;
	reg step_prev;
	reg [2:0] sck_sync;
	reg [1:0] cs_sync;
	reg [1:0] sdi_sync;
	reg [5:0] bit_cnt;
	reg [39:0] shift_in;
	reg [39:0] shift_out;
	reg [39:0] frame_word;
	reg frame_done;
	reg stall_seen;
	reg [6:0] strap_level;
	reg [31:0] next_prdata;
	reg next_slverr;
	wire signed [8:0] sin_val;
	wire signed [8:0] cos_val;
	wire step_rise;
	wire step_fall;
	wire active_edge;
	wire [3:0] res_code;
	wire [3:0] res_eff;
	wire [`SDM_CNT_W-1:0] step_size;
	wire serial_mode;
	wire selected;
	wire sck_rise;
	wire sck_fall;
	wire load_speed_on;
	wire apb_wr;
	wire apb_rd;

	assign serial_mode = interface_select; // [R7]
	// Second stage feeds edge logic; first stage is never looked at directly
	assign step_rise = step_sync[1] & ~step_prev; // [R17]
	assign step_fall = ~step_sync[1] & step_prev;
	assign active_edge = step_rise | (ctrl[`SDM_CTRL_EDGE] & step_fall); // [R1]
	// Codes above fullstep saturate to fullstep
	assign res_code = ctrl[`SDM_CTRL_RES_MSB:`SDM_CTRL_RES_LSB];
	assign res_eff = (res_code > `SDM_RES_MAX) ? `SDM_RES_MAX : res_code; // [R3]
	assign step_size = 10'h001 << res_eff; // [R4]
	assign selected = serial_mode & ~cs_sync[1]; // [R9]
	assign sck_rise = sck_sync[1] & ~sck_sync[2];
	assign sck_fall = ~sck_sync[1] & sck_sync[2];
	assign load_speed_on = serial_mode & load_speed_enable_in; // [R13]
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & ~penable & ~pwrite;

	// Sine and cosine share one table; cosine is a quarter turn ahead
	sdm_sine_lut u_sin (
		.phase(count),
		.value(sin_val)
	); // [R5]
	sdm_sine_lut u_cos (
		.phase(count + `SDM_COS_OFFSET),
		.value(cos_val)
	); // [R5]

	// Step and sense synchronisers; both share one delay so direction stays aligned
	always @(posedge clk) begin
		if (!rst_n) begin
			step_sync <= 2'h0;
			sense_sync <= 2'h0;
		end else begin
			step_sync <= {step_sync[0], step_in}; // [R17]
			sense_sync <= {sense_sync[0], travel_sense}; // [R17]
		end
	end

	// Edge reference; reset low matches the idle step level, so no false edge
	always @(posedge clk) begin
		if (!rst_n) begin
			step_prev <= 1'b0;
		end else begin
			step_prev <= step_sync[1];
		end
	end

	// Serial pin synchronisers; chip select resets to deselected
	always @(posedge clk) begin
		if (!rst_n) begin
			sck_sync <= 3'h0;
			cs_sync <= 2'h3;
			sdi_sync <= 2'h0;
		end else begin
			sck_sync <= {sck_sync[1:0], serial_clock_or_strap2};
			cs_sync <= {cs_sync[0], serial_select_n_or_strap3};
			sdi_sync <= {sdi_sync[0], serial_in_or_strap1};
		end
	end

	// Microstep counter; natural 10-bit overflow gives the wrap
	always @(posedge clk) begin
		if (!rst_n) begin
			count <= `SDM_CNT_RESET;
		end else if (active_edge && !step_hold) begin
			if (!sense_sync[1]) begin // [R2]
				count <= count + step_size; // [R4] [R18]
			end else begin
				count <= count - step_size; // [R4] [R18]
			end
		end
	end

	// Serial shifter: sample on clock rise, shift out on fall, 40 bits a frame
	always @(posedge clk) begin
		if (!rst_n) begin
			bit_cnt <= 6'h00;
			shift_in <= 40'h0;
			shift_out <= 40'h0;
			frame_word <= 40'h0;
			frame_done <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			if (!selected) begin
				bit_cnt <= 6'h00;
				shift_out <= {8'h00, 6'h00, count, 6'h00, stall_seen, load_speed_ready_out,
					power_stage_on, serial_mode, 6'h00};
			end else if (sck_rise) begin
				shift_in <= {shift_in[38:0], sdi_sync[1]};
				if (bit_cnt == `SDM_FRAME_BITS - 6'h01) begin // [R16]
					bit_cnt <= 6'h00;
					frame_word <= {shift_in[38:0], sdi_sync[1]};
					frame_done <= 1'b1;
				end else begin
					bit_cnt <= bit_cnt + 6'h01;
				end
			end else if (sck_fall) begin
				shift_out <= {shift_out[38:0], 1'b0}; // [R16]
			end
		end
	end

	// Control register; only a whole-word write at its own offset changes it
	always @(posedge clk) begin
		if (!rst_n) begin
			ctrl <= `SDM_CTRL_RESET;
		end else if (apb_wr && paddr == `SDM_ADDR_CTRL) begin
			ctrl <= pwdata; // [R1] [R3]
		end
	end

	// Direct coil word; a serial frame wins over an APB write in the same cycle
	always @(posedge clk) begin
		if (!rst_n) begin
			direct <= `SDM_DIRECT_RESET;
		end else if (frame_done && ctrl[`SDM_CTRL_DIRECT]) begin
			direct <= frame_word[31:0]; // [R6]
		end else if (apb_wr && paddr == `SDM_ADDR_DIRECT) begin
			direct <= pwdata; // [R6]
		end
	end

	// Slowdown request; only gated axes hold their steps
	always @(posedge clk) begin
		if (!rst_n) begin
			step_hold <= 1'b0;
		end else begin
			step_hold <= load_speed_on & stall_near & load_speed_gate_in; // [R15] [R14]
		end
	end

	// Ready drops while the load is near stall
	always @(posedge clk) begin
		if (!rst_n) begin
			load_speed_ready_out <= 1'b0;
		end else begin
			load_speed_ready_out <= load_speed_on & ~stall_near; // [R14]
		end
	end

	// Sticky stall flag for the controller; set wins over read clear
	always @(posedge clk) begin
		if (!rst_n) begin
			stall_seen <= 1'b0;
		end else if (load_speed_on && stall_near) begin
			stall_seen <= 1'b1; // [R15]
		end else if (psel && penable && !pwrite && paddr == `SDM_ADDR_STATUS) begin
			stall_seen <= 1'b0;
		end
	end

	// Strap levels latched only in standalone mode; serial mode keeps the last ones
	always @(posedge clk) begin
		if (!rst_n) begin
			strap_level <= 7'h00;
		end else if (!serial_mode) begin
			strap_level <= {power_stage_disable_n, load_speed_gate_in, load_speed_enable_in,
				serial_select_n_or_strap3, serial_clock_or_strap2, serial_in_or_strap1,
				serial_out_or_strap0_in}; // [R11]
		end
	end

	// Data out and its enable; released while deselected so others may drive the line
	always @(posedge clk) begin
		if (!rst_n) begin
			serial_out_or_strap0_out <= 1'b0;
			serial_out_or_strap0_oe <= 1'b0;
		end else begin
			serial_out_or_strap0_out <= selected & shift_out[39];
			serial_out_or_strap0_oe <= selected; // [R10]
		end
	end

	// Clock source follows the clock pin; the switch itself sits outside this block
	always @(posedge clk) begin
		if (!rst_n) begin
			clock_source_ext <= 1'b0;
		end else begin
			clock_source_ext <= ext_clock_present; // [R12]
		end
	end

	// Power stage enable; disable high floats the bridge outputs
	always @(posedge clk) begin
		if (!rst_n) begin
			power_stage_on <= 1'b0;
		end else begin
			power_stage_on <= ~power_stage_disable_n; // [R8]
		end
	end

	// Strap detection only makes sense when no controller drives the pins
	always @(posedge clk) begin
		if (!rst_n) begin
			strap_detect_en <= 1'b0;
		end else begin
			strap_detect_en <= ~serial_mode; // [R11]
		end
	end

	// Coil targets: zero while disabled, else the direct word or the table
	always @(posedge clk) begin
		if (!rst_n) begin
			coil_a <= 9'h000;
			coil_b <= 9'h000;
		end else begin
			if (power_stage_disable_n) begin
				coil_a <= 9'h000; // [R8]
				coil_b <= 9'h000; // [R8]
			end else if (ctrl[`SDM_CTRL_DIRECT]) begin
				coil_a <= direct[`SDM_DIR_A_MSB:0]; // [R6]
				coil_b <= direct[`SDM_DIR_B_MSB:`SDM_DIR_B_LSB]; // [R6]
			end else begin
				coil_a <= sin_val; // [R5]
				coil_b <= cos_val; // [R5]
			end
		end
	end

	// APB read mux; no wait state, as reads come from a register loaded in setup
	always @* begin
		next_prdata = 32'h0;
		next_slverr = 1'b0;
		case (paddr)
			`SDM_ADDR_CTRL: next_prdata = ctrl;
			`SDM_ADDR_DIRECT: next_prdata = direct;
			`SDM_ADDR_STATUS: next_prdata = {21'h0, strap_level, stall_seen, load_speed_ready_out,
				power_stage_on, serial_mode};
			`SDM_ADDR_COUNT: next_prdata = {22'h0, count};
			`SDM_ADDR_COIL: next_prdata = {7'h0, coil_b, 7'h0, coil_a};
			default: next_slverr = 1'b1;
		endcase
	end

	// Ready in the first access cycle; no further wait states are added
	always @(posedge clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
		end else begin
			pready <= psel & ~penable;
		end
	end

	// Error travels with ready so the master sees both at one edge
	always @(posedge clk) begin
		if (!rst_n) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel & ~penable & next_slverr;
		end
	end

	// Read data captured in setup so it stands through the access cycle
	always @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h0;
		end else if (apb_rd) begin
			prdata <= next_prdata;
		end
	end
endmodule

// >>> hdl/sdm_defs.vh
`ifndef SDM_DEFS_VH
`define SDM_DEFS_VH
// Register byte offsets
`define SDM_ADDR_CTRL 12'h000
`define SDM_ADDR_DIRECT 12'h004
`define SDM_ADDR_STATUS 12'h008
`define SDM_ADDR_COUNT 12'h00c
`define SDM_ADDR_COIL 12'h010
// Control register fields
`define SDM_CTRL_EDGE 0
`define SDM_CTRL_DIRECT 1
`define SDM_CTRL_RES_LSB 4
`define SDM_CTRL_RES_MSB 7
`define SDM_CTRL_RESET 32'h00000000
// Direct coil word fields: coil A [8:0], coil B [24:16], 9-bit signed
`define SDM_DIR_A_MSB 8
`define SDM_DIR_B_LSB 16
`define SDM_DIR_B_MSB 24
`define SDM_DIRECT_RESET 32'h00000000
// Microstep counter
`define SDM_CNT_W 10
`define SDM_CNT_RESET 10'h000
`define SDM_COS_OFFSET 10'h100
// Resolution codes: 0 = 256 microsteps ... 8 = fullstep
`define SDM_RES_MAX 4'h8
// Serial frame length in bits
`define SDM_FRAME_BITS 6'h28
`endif

// >>> hdl/sdm_sine_lut.v
`timescale 1ns/1ps
// Quarter-wave sine from a small table with linear interpolation
module sdm_sine_lut (
	input wire [9:0] phase, // Counter phase, 1024 per electrical turn
	output reg signed [8:0] value // Signed coil current target
);
	reg [7:0] quarter;
	reg [7:0] mag;
	reg [7:0] lo;
	reg [7:0] hi;
	reg [8:0] diff;
	reg [11:0] prod;
	// Table of 17 points over a quarter wave; interpolation keeps it tiny
	function [7:0] pt;
		input [4:0] i;
		begin
			case (i)
				5'h00: pt = 8'h00; 5'h01: pt = 8'h19; 5'h02: pt = 8'h31; 5'h03: pt = 8'h4a;
				5'h04: pt = 8'h61; 5'h05: pt = 8'h78; 5'h06: pt = 8'h8e; 5'h07: pt = 8'ha2;
				5'h08: pt = 8'hb5; 5'h09: pt = 8'hc7; 5'h0a: pt = 8'hd4; 5'h0b: pt = 8'he1;
				5'h0c: pt = 8'heb; 5'h0d: pt = 8'hf4; 5'h0e: pt = 8'hfa; 5'h0f: pt = 8'hfd;
				default: pt = 8'hff;
			endcase
		end
	endfunction
	// Mirror odd quadrants, negate the second half turn
	always @* begin
		quarter = phase[8] ? ~phase[7:0] : phase[7:0];
		lo = pt({1'b0, quarter[7:4]});
		hi = pt({1'b0, quarter[7:4]} + 5'h01);
		diff = {1'b0, hi} - {1'b0, lo};
		// Product kept at 12 bits; an 8-bit context would drop its top bits
		prod = {4'h0, diff[7:0]} * {8'h00, quarter[3:0]};
		mag = lo + prod[11:4];
		value = phase[9] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
	end
endmodule

// >>> testbench/sdm_sequencer_sva.sv
`timescale 1ns/1ps
module sdm_chk (
	input wire clk, // System clock
	input wire rst_n, // Sync reset, active low
	input wire psel, // APB select
	input wire penable, // APB access phase
	input wire pready, // APB ready
	input wire pslverr, // APB error
	input wire power_stage_disable_n, // High turns power stage off
	input wire power_stage_on, // Power stage enable
	input wire signed [8:0] coil_a, // Coil A target
	input wire signed [8:0] coil_b, // Coil B target
	input wire interface_select, // Serial mode select
	input wire strap_detect_en, // Strap detection enable
	input wire ext_clock_present, // External clock seen
	input wire clock_source_ext, // Clock source select
	input wire serial_select_n_or_strap3, // Chip select
	input wire serial_out_or_strap0_oe, // Data out enable
	input wire load_speed_enable_in, // Load-speed enable
	input wire step_hold // Slowdown request
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_setup; psel && !penable; endsequence
	sequence s_answer; pready; endsequence
	property p_ready; s_setup |=> s_answer; endproperty
	a_ready: assert property (p_ready) else $error("pready missing after setup");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("pslverr without pready");
	property p_pwr; $past(rst_n) |-> power_stage_on == !$past(power_stage_disable_n); endproperty
	a_pwr: assert property (p_pwr) else $error("power stage state wrong");
	property p_coil_off; power_stage_disable_n [*2] |-> coil_a == 9'h000 && coil_b == 9'h000; endproperty
	a_coil_off: assert property (p_coil_off) else $error("coils driven while disabled");
	property p_strap; $past(rst_n) |-> strap_detect_en == !$past(interface_select); endproperty
	a_strap: assert property (p_strap) else $error("strap detection in wrong mode");
	property p_clk; ext_clock_present |=> clock_source_ext; endproperty
	a_clk: assert property (p_clk) else $error("external clock not selected");
	// Released output must stay off whether deselected or in standalone mode
	property p_oe; (serial_select_n_or_strap3 || !interface_select) [*4] |-> !serial_out_or_strap0_oe; endproperty
	a_oe: assert property (p_oe) else $error("data out driven while deselected");
	property p_hold; !load_speed_enable_in [*4] |-> !step_hold; endproperty
	a_hold: assert property (p_hold) else $error("slowdown while feature off");
endmodule
bind sdm_sequencer sdm_chk sdm_chk_inst (.clk, .rst_n, .psel, .penable, .pready, .pslverr,
	.power_stage_disable_n, .power_stage_on, .coil_a, .coil_b, .interface_select, .strap_detect_en,
	.ext_clock_present, .clock_source_ext, .serial_select_n_or_strap3, .serial_out_or_strap0_oe,
	.load_speed_enable_in, .step_hold);

// >>> testbench/sdm_step_src.sv
`timescale 1ns/1ps
module sdm_step_src (
	input wire clk, // System clock
	input wire start, // Begin a burst
	input wire dir, // Direction of the burst
	input wire [3:0] n, // Step edges to send
	input wire hold, // Slowdown request
	output reg step_in, // Step line
	output reg travel_sense, // Direction line
	output reg busy // Burst running
);
	reg [3:0] left;
	reg [2:0] t;
	initial begin
		step_in = 1'b0;
		travel_sense = 1'b0;
		busy = 1'b0;
		left = 4'h0;
		t = 3'h0;
	end
	// Direction settles a whole slot ahead and edges are 8 cycles apart, beyond the sync delay
	always @(posedge clk) begin
		if (!busy && start) begin
			travel_sense <= dir;
			left <= n;
			t <= 3'h0;
			busy <= 1'b1;
		end else if (busy && !hold) begin // Pauses while slowed down
			t <= t + 3'h1;
			if (t == 3'h7 && left == 4'h0)
				busy <= 1'b0;
			else if (t == 3'h7) begin
				step_in <= ~step_in;
				left <= left - 4'h1;
			end
		end
	end
endmodule

// >>> testbench/step_dir_microstep_sequencer_tb.sv
`timescale 1ns/1ps
`include "sdm_defs.vh"
module step_dir_microstep_sequencer_tb;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, step_in, travel_sense, busy, start, dir, e;
	logic interface_select, power_stage_disable_n, serial_select_n_or_strap3, load_speed_enable_in;
	logic ext_clock_present, serial_out_or_strap0_out, serial_out_or_strap0_oe, load_speed_ready_out;
	logic step_hold, clock_source_ext, power_stage_on, strap_detect_en;
	logic serial_clock_or_strap2, serial_in_or_strap1, load_speed_gate_in, stall_near;
	logic [39:0] sw;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, exp;
	logic [3:0] n;
	logic signed [8:0] coil_a, coil_b;
	int num_errors = 0, samples_checked = 0, i;
	sdm_sequencer sdm_sequencer_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .step_in, .travel_sense, .interface_select, .power_stage_disable_n,
		.serial_select_n_or_strap3, .serial_clock_or_strap2, .serial_in_or_strap1,
		.serial_out_or_strap0_in(1'b1), .serial_out_or_strap0_out, .serial_out_or_strap0_oe,
		.load_speed_enable_in, .load_speed_gate_in, .stall_near, .load_speed_ready_out,
		.step_hold, .ext_clock_present, .clock_source_ext, .power_stage_on, .strap_detect_en, .coil_a, .coil_b);
	sdm_step_src sdm_step_src_inst (.clk, .start, .dir, .n, .hold(step_hold), .step_in, .travel_sense, .busy);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task stop_test;
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, x, g);
		end
	endtask
	// One APB transfer, entered just after a rising edge; waits for pready under a bound
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			num_errors++;
			stop_test;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk("read", x, r);
	endtask
	// Sends k step edges, then allows the sync and update latency to pass
	task stp(input logic d, input logic [3:0] k);
		int m;
		start <= 1'b1;
		dir <= d;
		n <= k;
		@(posedge clk) start <= 1'b0;
		m = 0;
		do begin
			@(posedge clk);
			m++;
		end while (busy !== 1'b0 && m < 300);
		if (m >= 300) begin
			num_errors++;
			stop_test;
		end
		repeat (8) @(posedge clk);
	endtask
	// One 40-bit frame, MSB first; a 6-clock half period covers the sync delay
	task spi(input logic [39:0] w);
		int b;
		serial_select_n_or_strap3 <= 1'b0;
		for (b = 39; b >= 0; b--) begin
			serial_in_or_strap1 <= w[b];
			repeat (6) @(posedge clk);
			sw = {sw[38:0], serial_out_or_strap0_out};
			serial_clock_or_strap2 <= 1'b1;
			repeat (6) @(posedge clk);
			serial_clock_or_strap2 <= 1'b0;
		end
		repeat (6) @(posedge clk);
		serial_select_n_or_strap3 <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	// Main sequence; load-speed feature off until its own checks at the end, chip select deselected outside use
	initial begin
		{rst_n, psel, penable, pwrite, start, dir, ext_clock_present, load_speed_enable_in} = 8'h00;
		{paddr, pwdata, n} = 48'h0;
		{serial_clock_or_strap2, serial_in_or_strap1, load_speed_gate_in, stall_near} = 4'h0;
		sw = 40'h0;
		{interface_select, serial_select_n_or_strap3, power_stage_disable_n} = 3'b110;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`SDM_ADDR_CTRL, `SDM_CTRL_RESET);
		rd(`SDM_ADDR_DIRECT, `SDM_DIRECT_RESET);
		rd(`SDM_ADDR_COUNT, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk("pslverr", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		exp = 32'h0;
		// Rising-only mode: a full pulse is one step of 2^code
		for (i = 0; i < 9; i++) begin
			apb(1'b1, `SDM_ADDR_CTRL, i << 4);
			stp(1'b0, 4'h2);
			exp = (exp + (32'h1 << i)) & 32'h3ff;
			rd(`SDM_ADDR_COUNT, exp);
		end
		apb(1'b1, `SDM_ADDR_CTRL, 32'h81);
		stp(1'b1, 4'h2);
		rd(`SDM_ADDR_COUNT, 32'h3ff);
		apb(1'b1, `SDM_ADDR_CTRL, 32'h2);
		apb(1'b1, `SDM_ADDR_DIRECT, 32'h00f00105);
		repeat (3) @(posedge clk);
		chk("coil_a", 32'h105, {23'h0, coil_a});
		chk("coil_b", 32'h0f0, {23'h0, coil_b});
		spi(40'h0000aa0011);
		chk("status word", 32'h03ff00c0, sw[31:0]);
		chk("status top", 32'h0, {24'h0, sw[39:32]});
		chk("coil_a serial", 32'h011, {23'h0, coil_a});
		chk("coil_b serial", 32'h0aa, {23'h0, coil_b});
		power_stage_disable_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk("coil_a off", 32'h0, {23'h0, coil_a});
		chk("power_stage_on", 32'h0, {31'h0, power_stage_on});
		{power_stage_disable_n, interface_select, ext_clock_present, serial_select_n_or_strap3} <= 4'h2;
		repeat (6) @(posedge clk);
		chk("strap_detect_en", 32'h1, {31'h0, strap_detect_en});
		chk("clock_source_ext", 32'h1, {31'h0, clock_source_ext});
		interface_select <= 1'b1;
		repeat (6) @(posedge clk);
		chk("sdo_oe selected", 32'h1, {31'h0, serial_out_or_strap0_oe});
		chk("strap_detect_en", 32'h0, {31'h0, strap_detect_en});
		serial_select_n_or_strap3 <= 1'b1;
		repeat (6) @(posedge clk);
		chk("sdo_oe released", 32'h0, {31'h0, serial_out_or_strap0_oe});
		load_speed_enable_in <= 1'b1;
		repeat (4) @(posedge clk);
		chk("ready", 32'h1, {31'h0, load_speed_ready_out});
		{stall_near, load_speed_gate_in} <= 2'h3;
		repeat (4) @(posedge clk);
		chk("step_hold", 32'h1, {31'h0, step_hold});
		chk("ready stalled", 32'h0, {31'h0, load_speed_ready_out});
		rd(`SDM_ADDR_STATUS, 32'h3b);
		{stall_near, load_speed_gate_in} <= 2'h0;
		repeat (4) @(posedge clk);
		rd(`SDM_ADDR_STATUS, 32'h3f);
		rd(`SDM_ADDR_STATUS, 32'h37);
		load_speed_enable_in <= 1'b0;
		repeat (6) @(posedge clk);
		stop_test;
	end
endmodule
